// ===== hdl/acb_pkg.sv
// Summary of operation
// - counter is 16 bits, two byte registers
// - low-byte read snapshots high byte for next
// - byte reads never disturb counting
// - wrap from ffff to zero sets flag
// - interrupt only while overflow enable set
// - flag stays until software clears it
// - idle control bit suspends counting in idle
// - three-bit code picks the count source
// - external input counts falling edges, slow
// - divided oscillator synchronised before use
package acb_pkg;

   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [7:0] OFF_COUNT_LOW  = 8'h00;
   localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
   localparam logic [7:0] OFF_MODE       = 8'h08;
   localparam logic [7:0] OFF_STATUS     = 8'h0c;
   localparam logic [7:0] OFF_MASK       = 8'h10;

   // ****************************************
   // mode register fields
   // ****************************************
   localparam int MODE_OIE_BIT   = 0;
   localparam int MODE_SEL_LSB   = 1;
   localparam int MODE_FLAG_BIT  = 6;
   localparam int MODE_IDLE_BIT  = 7;
   localparam int STAT_OVF_BIT   = 0;

   // ****************************************
   // timebase codes
   // ****************************************
   localparam logic [2:0] TB_DIV12  = 3'h0;
   localparam logic [2:0] TB_DIV4   = 3'h1;
   localparam logic [2:0] TB_T0_OVF = 3'h2;
   localparam logic [2:0] TB_EXT    = 3'h3;
   localparam logic [2:0] TB_SYSCLK = 3'h4;
   localparam logic [2:0] TB_OSC8   = 3'h5;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int DIV_SLOW      = 12;
   localparam int DIV_FAST      = 4;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] COUNT_TOP = 16'hffff;
   localparam logic [7:0]  BYTE_RST  = 8'h00;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ACK  = 2'h1
   } acb_bus_st_t;

   typedef struct packed {
      logic       idle_suspend_ctl;
      logic [2:0] timebase_select;
      logic       overflow_irq_enable;
   } acb_mode_t;

   localparam acb_mode_t MODE_RST = '{1'b0, 3'h0, 1'b0};

   typedef struct packed {
      acb_bus_st_t st;
      logic        ack;
      logic [31:0] rdat;
      logic [15:0] cnt;
      logic [7:0]  snap;
      acb_mode_t   mode;
      logic        overflow_flag;
      logic        mask;
      logic        irq;
   } acb_state_t;

endpackage

// ===== hdl/acb_sync.sv
`timescale 1ns/10ps
module acb_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         arst_n_in,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   // ****************************************
   // two flops; stage one feeds stage two only
   // ****************************************
   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } acb_sync_st_t;

   acb_sync_st_t q;
   acb_sync_st_t d;

   if (W < 1) begin : g_chk
      $error("acb_sync width must be positive");
   end

   always_comb begin
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;

endmodule

// ===== hdl/acb_tick.sv
`timescale 1ns/10ps
module acb_tick (
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       arst_n_in,
   // sources, ext and osc already synchronised
   input  wire logic [2:0] sel_in,
   input  wire logic       t0_ovf_in,
   input  wire logic       ext_in,
   input  wire logic       osc8_in,
   // one-cycle event
   output logic            tick_out
);

   // ****************************************
   // timebase generation
   // ****************************************
   typedef struct packed {
      logic [3:0] div12;
      logic [1:0] div4;
      logic       ext_prev;
      logic       osc_prev;
      logic       tick;
   } acb_tick_st_t;

   acb_tick_st_t q;
   acb_tick_st_t d;

   always_comb begin
      d = q;
      d.div12 = (q.div12 == 4'(acb_pkg::DIV_SLOW - 1)) ? 4'h0 : q.div12 + 4'h1;
      d.div4 = q.div4 + 2'h1;
      d.ext_prev = ext_in;
      d.osc_prev = osc8_in;
      case (sel_in)
         acb_pkg::TB_DIV12:  d.tick = (q.div12 == 4'h0);
         acb_pkg::TB_DIV4:   d.tick = (q.div4 == 2'h0);
         acb_pkg::TB_T0_OVF: d.tick = t0_ovf_in;
         acb_pkg::TB_EXT:    d.tick = q.ext_prev & ~ext_in;
         acb_pkg::TB_SYSCLK: d.tick = 1'b1;
         acb_pkg::TB_OSC8:   d.tick = ~q.osc_prev & osc8_in;
         default:            d.tick = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick_out = q.tick;

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   a_ext_fall_tick: assert property (
      sel_in == acb_pkg::TB_EXT && $stable(sel_in) && q.ext_prev && !ext_in |=> tick_out)
      else $error("falling edge on external input gave no event");
   a_reserved_quiet: assert property (
      sel_in[2:1] == 2'h3 |=> !tick_out)
      else $error("reserved timebase produced an event");
   a_sysclk_tick: assert property (
      sel_in == acb_pkg::TB_SYSCLK |=> tick_out)
      else $error("system clock timebase missed a cycle");

endmodule

// ===== hdl/acb_top.sv
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
module acb_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              arst_n_in,
   // wishbone slave
   input  wire logic              wb_cyc_in,
   input  wire logic              wb_stb_in,
   input  wire logic              wb_we_in,
   input  wire logic [ADDR_W-1:0] wb_adr_in,
   input  wire logic [3:0]        wb_sel_in,
   input  wire logic [31:0]       wb_dat_in,
   output logic      [31:0]       wb_dat_out,
   output logic                   wb_ack_out,
   // timebase sources and cpu state
   input  wire logic              timer0_ovf_in,
   input  wire logic              external_count_input_in,
   input  wire logic              ext_osc_div8_in,
   input  wire logic              cpu_idle_in,
   // interrupt
   output logic                   irq_out
);

   // ****************************************
   // elaboration checks
   // ****************************************
   if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
      $error("acb_top address width must be 5 to 8");
   end

   // ****************************************
   // address decode
   // ****************************************
   function automatic logic hit(input logic [ADDR_W-1:0] adr,
                                input logic [7:0]        off);
      hit = (8'(adr) == off);
   endfunction

   // ****************************************
   // state
   // ****************************************
   acb_pkg::acb_state_t q;
   acb_pkg::acb_state_t d;

   logic [1:0] pins_sync;
   logic       tick;
   logic       cnt_en;
   logic       acc;
   logic       rd_acc;
   logic       wr_acc;
   logic       wr_lo;
   logic       wr_hi;
   logic       ovf_clr;
   logic       wrap;

   // ****************************************
   // pin synchronisers and timebase
   // ****************************************
   acb_sync #(
      .W (2)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .async_in   ({ext_osc_div8_in, external_count_input_in}),
      .sync_out   (pins_sync)
   );

   // osc divider is a foreign clock; it only reaches us through u_sync
   acb_tick u_tick (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .sel_in     (q.mode.timebase_select),
      .t0_ovf_in  (timer0_ovf_in),
      .ext_in     (pins_sync[0]),
      .osc8_in    (pins_sync[1]),
      .tick_out   (tick)
   );

   // ****************************************
   // access qualifiers
   // ****************************************
   // one access per request; ack lags it by one edge
   assign acc     = wb_cyc_in & wb_stb_in & (q.st == acb_pkg::ST_IDLE);
   assign rd_acc  = acc & ~wb_we_in;
   assign wr_acc  = acc & wb_we_in & wb_sel_in[0];
   assign wr_lo   = wr_acc & hit(wb_adr_in, acb_pkg::OFF_COUNT_LOW);
   assign wr_hi   = wr_acc & hit(wb_adr_in, acb_pkg::OFF_COUNT_HIGH);
   assign ovf_clr = wr_acc & hit(wb_adr_in, acb_pkg::OFF_STATUS)
                    & wb_dat_in[acb_pkg::STAT_OVF_BIT];
   // idle only stops counting when software asked for it
   assign cnt_en  = tick & ~(cpu_idle_in & q.mode.idle_suspend_ctl);
   assign wrap    = cnt_en & (q.cnt == acb_pkg::COUNT_TOP);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      d = q;
      d.ack = 1'b0;
      // count first so that a bus write below can override it
      if (cnt_en) begin
         d.cnt = q.cnt + 16'h0001;
      end
      case (q.st)
         acb_pkg::ST_IDLE: begin
            if (acc) begin
               d.st = acb_pkg::ST_ACK;
               d.ack = 1'b1;
               d.rdat = '0;
               if (rd_acc) begin
                  if (hit(wb_adr_in, acb_pkg::OFF_COUNT_LOW)) begin
                     d.rdat[7:0] = q.cnt[7:0];
                     d.snap = q.cnt[15:8];
                  end else if (hit(wb_adr_in, acb_pkg::OFF_COUNT_HIGH)) begin
                     d.rdat[7:0] = q.snap;
                  end else if (hit(wb_adr_in, acb_pkg::OFF_MODE)) begin
                     d.rdat[acb_pkg::MODE_IDLE_BIT] = q.mode.idle_suspend_ctl;
                     d.rdat[acb_pkg::MODE_FLAG_BIT] = q.overflow_flag;
                     d.rdat[acb_pkg::MODE_SEL_LSB +: 3] = q.mode.timebase_select;
                     d.rdat[acb_pkg::MODE_OIE_BIT] = q.mode.overflow_irq_enable;
                  end else if (hit(wb_adr_in, acb_pkg::OFF_STATUS)) begin
                     d.rdat[acb_pkg::STAT_OVF_BIT] = q.overflow_flag;
                  end else if (hit(wb_adr_in, acb_pkg::OFF_MASK)) begin
                     d.rdat[acb_pkg::STAT_OVF_BIT] = q.mask;
                  end
               end
               if (wr_lo) begin
                  d.cnt[7:0] = wb_dat_in[7:0];
               end
               if (wr_hi) begin
                  d.cnt[15:8] = wb_dat_in[7:0];
               end
               if (wr_acc && hit(wb_adr_in, acb_pkg::OFF_MODE)) begin
                  d.mode.idle_suspend_ctl = wb_dat_in[acb_pkg::MODE_IDLE_BIT];
                  d.mode.timebase_select = wb_dat_in[acb_pkg::MODE_SEL_LSB +: 3];
                  d.mode.overflow_irq_enable = wb_dat_in[acb_pkg::MODE_OIE_BIT];
               end
               if (wr_acc && hit(wb_adr_in, acb_pkg::OFF_MASK)) begin
                  d.mask = wb_dat_in[acb_pkg::STAT_OVF_BIT];
               end
               if (ovf_clr) begin
                  d.overflow_flag = 1'b0;
               end
            end
         end
         acb_pkg::ST_ACK: begin
            d.st = acb_pkg::ST_IDLE;
         end
         default: begin
            d.st = acb_pkg::ST_IDLE;
         end
      endcase
      // a wrap in the clearing cycle still leaves the flag set
      if (wrap) begin
         d.overflow_flag = 1'b1;
      end
      d.irq = d.overflow_flag & d.mode.overflow_irq_enable & d.mask;
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q.st <= acb_pkg::ST_IDLE;
         q.ack <= 1'b0;
         q.rdat <= '0;
         q.cnt <= acb_pkg::COUNT_RST;
         q.snap <= acb_pkg::BYTE_RST;
         q.mode <= acb_pkg::MODE_RST;
         q.overflow_flag <= 1'b0;
         q.mask <= 1'b0;
         q.irq <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign wb_dat_out = q.rdat;
   assign wb_ack_out = q.ack;
   assign irq_out    = q.irq;

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   a_ack_after_req: assert property (
      acc |=> wb_ack_out ##1 !wb_ack_out)
      else $error("bus request not acked for exactly one cycle");

   a_snap_on_low: assert property (
      rd_acc && hit(wb_adr_in, acb_pkg::OFF_COUNT_LOW)
      |=> q.snap == $past(q.cnt[15:8]))
      else $error("low read did not capture high byte");

   a_high_from_snap: assert property (
      rd_acc && hit(wb_adr_in, acb_pkg::OFF_COUNT_HIGH)
      |=> wb_dat_out == {24'h000000, $past(q.snap)})
      else $error("high read did not return snapshot");

   a_read_keeps_count: assert property (
      rd_acc && cnt_en |=> q.cnt == $past(q.cnt) + 16'h0001)
      else $error("read disturbed the counter");

   a_inc_by_one: assert property (
      cnt_en && !wr_lo && !wr_hi |=> q.cnt == $past(q.cnt) + 16'h0001)
      else $error("counter did not advance by one");

   a_hold_no_event: assert property (
      !cnt_en && !wr_lo && !wr_hi |=> $stable(q.cnt))
      else $error("counter moved without an event");

   a_wrap_sets_flag: assert property (
      wrap |=> q.overflow_flag && q.cnt == acb_pkg::COUNT_RST || $past(wr_lo || wr_hi))
      else $error("wrap did not set overflow flag");

   a_flag_sticky: assert property (
      q.overflow_flag && !ovf_clr |=> q.overflow_flag)
      else $error("overflow flag cleared without software");

   a_irq_gated: assert property (
      ##1 irq_out == (q.overflow_flag && q.mode.overflow_irq_enable && q.mask))
      else $error("interrupt not gated by enable and mask");

   a_idle_freeze: assert property (
      cpu_idle_in && q.mode.idle_suspend_ctl && !wr_lo && !wr_hi |=> $stable(q.cnt))
      else $error("counter ran in suspended idle");

   a_idle_runs: assert property (
      cpu_idle_in && !q.mode.idle_suspend_ctl && tick && !wr_lo && !wr_hi
      |=> q.cnt != $past(q.cnt))
      else $error("counter stopped in idle while allowed");

   c_overflow: cover property (wrap ##1 irq_out);
   c_coherent_read: cover property (
      rd_acc && hit(wb_adr_in, acb_pkg::OFF_COUNT_LOW) ##3
      rd_acc && hit(wb_adr_in, acb_pkg::OFF_COUNT_HIGH));
   c_clear_vs_wrap: cover property (ovf_clr && wrap);
   c_ext_mode: cover property (
      q.mode.timebase_select == acb_pkg::TB_EXT && cnt_en);

endmodule

// ===== tb/acb_top_tb.sv
`timescale 1ns/10ps
module acb_top_tb;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic        clk_sys   = 1'b0;
   logic        arst_n    = 1'b0;
   logic        cyc       = 1'b0;
   logic        stb       = 1'b0;
   logic        we        = 1'b0;
   logic [7:0]  adr       = 8'h00;
   logic [3:0]  sel       = 4'h0;
   logic [31:0] wdat      = 32'h0000_0000;
   logic        t0        = 1'b0;
   logic        ext       = 1'b1;
   logic        osc       = 1'b0;
   logic        idle      = 1'b0;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   int          err_count = 0;
   int          num_checks = 0;

   always #(acb_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

   acb_top #(.ADDR_W(8)) dut (
      .clk_sys_in              (clk_sys),
      .arst_n_in               (arst_n),
      .wb_cyc_in               (cyc),
      .wb_stb_in               (stb),
      .wb_we_in                (we),
      .wb_adr_in               (adr),
      .wb_sel_in               (sel),
      .wb_dat_in               (wdat),
      .wb_dat_out              (rdat),
      .wb_ack_out              (ack),
      .timer0_ovf_in           (t0),
      .external_count_input_in (ext),
      .ext_osc_div8_in         (osc),
      .cpu_idle_in             (idle),
      .irq_out                 (irq)
   );

   // ****************************************
   // bus cycles and comparisons
   // ****************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic check_range(input logic [15:0] got, input logic [15:0] lo,
                              input logic [15:0] hi, input string msg);
      num_checks++;
      if (!(got >= lo && got <= hi)) begin
         err_count++;
         $display("mismatch at %0t: %s got %0d outside %0d..%0d", $time, msg, got, lo, hi);
      end
   endtask

   // request held until ack is sampled, then one idle cycle follows
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'hf;
      wdat <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) check(32'h1, 32'h0, "bus answer missing");
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(q, exp, msg);
   endtask

   task automatic read16(output logic [15:0] v);
      logic [31:0] l;
      logic [31:0] h;
      wb(1'b0, acb_pkg::OFF_COUNT_LOW, 32'h0, l);
      wb(1'b0, acb_pkg::OFF_COUNT_HIGH, 32'h0, h);
      v = {h[7:0], l[7:0]};
   endtask

   function automatic logic [31:0] mode_v(logic idl, logic [2:0] s, logic oie);
      return {24'h00_0000, idl, 3'h0, s, oie};
   endfunction

   task automatic pulse_t0(input int n);
      repeat (n) begin
         @(posedge clk_sys) t0 <= 1'b1;
         @(posedge clk_sys) t0 <= 1'b0;
         repeat (2) @(posedge clk_sys);
      end
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic settle_irq(input logic exp, input string msg);
      repeat (3) @(posedge clk_sys);
      check({31'h0, irq}, {31'h0, exp}, msg);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      rd_chk(acb_pkg::OFF_COUNT_LOW, 32'h0, "low after reset");
      rd_chk(acb_pkg::OFF_COUNT_HIGH, 32'h0, "high after reset");
      rd_chk(acb_pkg::OFF_MODE, 32'h0, "mode after reset");
      rd_chk(acb_pkg::OFF_STATUS, 32'h0, "status after reset");
      rd_chk(acb_pkg::OFF_MASK, 32'h0, "mask after reset");
      rd_chk(8'h14, 32'h0, "unmapped read");
      $display("test reset done");
   endtask

   task automatic t_snapshot();
      wr(acb_pkg::OFF_MODE, mode_v(1'b0, acb_pkg::TB_T0_OVF, 1'b0));
      wr(acb_pkg::OFF_COUNT_LOW, 32'h0000_00ff);
      wr(acb_pkg::OFF_COUNT_HIGH, 32'h0000_0012);
      rd_chk(acb_pkg::OFF_COUNT_LOW, 32'h0000_00ff, "low before carry");
      pulse_t0(1);
      rd_chk(acb_pkg::OFF_COUNT_HIGH, 32'h0000_0012, "stale snapshot");
      rd_chk(acb_pkg::OFF_COUNT_LOW, 32'h0000_0000, "low after carry");
      rd_chk(acb_pkg::OFF_COUNT_HIGH, 32'h0000_0013, "fresh snapshot");
      $display("test snapshot done");
   endtask

   task automatic t_sources();
      logic [2:0]  codes [3] = '{acb_pkg::TB_DIV12, acb_pkg::TB_DIV4, acb_pkg::TB_SYSCLK};
      int          divs  [3] = '{acb_pkg::DIV_SLOW, acb_pkg::DIV_FAST, 1};
      logic [15:0] a;
      logic [15:0] b;
      // read overhead widens the window by a few cycles
      for (int i = 0; i < 3; i++) begin
         wr(acb_pkg::OFF_MODE, mode_v(1'b0, codes[i], 1'b0));
         read16(a);
         repeat (240) @(posedge clk_sys);
         read16(b);
         check_range(b - a, 16'(240 / divs[i] - 1), 16'(252 / divs[i] + 1), "rate");
      end
      wr(acb_pkg::OFF_MODE, mode_v(1'b0, acb_pkg::TB_EXT, 1'b0));
      read16(a);
      repeat (5) begin
         @(posedge clk_sys) ext <= 1'b0;
         repeat (8) @(posedge clk_sys);
         ext <= 1'b1;
         repeat (8) @(posedge clk_sys);
      end
      read16(b);
      check({16'h0, b - a}, 32'd5, "falling edges");
      wr(acb_pkg::OFF_MODE, mode_v(1'b0, acb_pkg::TB_OSC8, 1'b0));
      read16(a);
      repeat (3) begin
         @(posedge clk_sys) osc <= 1'b1;
         repeat (8) @(posedge clk_sys);
         osc <= 1'b0;
         repeat (8) @(posedge clk_sys);
      end
      read16(b);
      check({16'h0, b - a}, 32'd3, "oscillator periods");
      for (int c = 6; c < 8; c++) begin
         wr(acb_pkg::OFF_MODE, mode_v(1'b0, 3'(c), 1'b0));
         read16(a);
         repeat (60) @(posedge clk_sys);
         read16(b);
         check({16'h0, b}, {16'h0, a}, "reserved code counts");
      end
      $display("test sources done");
   endtask

   task automatic t_overflow();
      wr(acb_pkg::OFF_MODE, mode_v(1'b0, acb_pkg::TB_T0_OVF, 1'b0));
      wr(acb_pkg::OFF_MASK, 32'h1);
      wr(acb_pkg::OFF_COUNT_LOW, 32'h0000_00ff);
      wr(acb_pkg::OFF_COUNT_HIGH, 32'h0000_00ff);
      rd_chk(acb_pkg::OFF_STATUS, 32'h0, "flag before wrap");
      pulse_t0(1);
      rd_chk(acb_pkg::OFF_COUNT_LOW, 32'h0, "low after wrap");
      rd_chk(acb_pkg::OFF_STATUS, 32'h1, "flag after wrap");
      rd_chk(acb_pkg::OFF_MODE, 32'h0000_0044, "mode mirror");
      settle_irq(1'b0, "irq with enable off");
      wr(acb_pkg::OFF_MODE, mode_v(1'b0, acb_pkg::TB_T0_OVF, 1'b1));
      settle_irq(1'b1, "irq enabled");
      wr(acb_pkg::OFF_MASK, 32'h0);
      settle_irq(1'b0, "irq masked");
      wr(acb_pkg::OFF_MASK, 32'h1);
      settle_irq(1'b1, "irq unmasked");
      rd_chk(acb_pkg::OFF_STATUS, 32'h1, "flag stays set");
      wr(acb_pkg::OFF_STATUS, 32'h1);
      rd_chk(acb_pkg::OFF_STATUS, 32'h0, "flag cleared");
      settle_irq(1'b0, "irq after clear");
      $display("test overflow done");
   endtask

   task automatic t_idle();
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] c;
      idle <= 1'b1;
      wr(acb_pkg::OFF_MODE, mode_v(1'b0, acb_pkg::TB_T0_OVF, 1'b0));
      read16(a);
      pulse_t0(2);
      read16(b);
      check({16'h0, b}, {16'h0, a + 16'h2}, "idle counting");
      wr(acb_pkg::OFF_MODE, mode_v(1'b1, acb_pkg::TB_T0_OVF, 1'b0));
      pulse_t0(2);
      read16(c);
      check({16'h0, c}, {16'h0, b}, "idle suspended");
      idle <= 1'b0;
      pulse_t0(1);
      read16(c);
      check({16'h0, c}, {16'h0, b + 16'h1}, "awake counting");
      $display("test idle done");
   endtask

   // ****************************************
   // sequence and watchdog
   // ****************************************
   initial begin
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_reset();
      t_snapshot();
      t_sources();
      t_overflow();
      t_idle();
      print_verdict();
   end

   // tests take about 1300 cycles
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule
